// *** design/asm_status_mode.sv ***
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "asm_regs.svh"
module asm_status_mode (
  // Clock, reset and enable.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address.
  input wire logic saxi_awvalid,
  output logic saxi_awready,
  input wire asm_pkg::asm_addr_t saxi_awaddr,
  // AXI4-Lite write data.
  input wire logic saxi_wvalid,
  output logic saxi_wready,
  input wire asm_pkg::asm_data_t saxi_wdata,
  input wire logic [3:0] saxi_wstrb,
  // AXI4-Lite write response.
  output logic saxi_bvalid,
  input wire logic saxi_bready,
  output logic [1:0] saxi_bresp,
  // AXI4-Lite read address.
  input wire logic saxi_arvalid,
  output logic saxi_arready,
  input wire asm_pkg::asm_addr_t saxi_araddr,
  // AXI4-Lite read data.
  output logic saxi_rvalid,
  input wire logic saxi_rready,
  output asm_pkg::asm_data_t saxi_rdata,
  output logic [1:0] saxi_rresp,
  // Converter events and state.
  input wire logic lock_state,
  input wire logic resync_pulse,
  input wire logic map_crc_change_pulse,
  input wire logic rx_crc_error_pulse,
  input wire logic [2:0] chan_sample_pulse,
  input wire logic sample_data_read_pulse,
  // Configuration to the converter.
  output logic map_crc_enable,
  output logic rx_crc_enable,
  output logic crc_poly_select,
  output logic [1:0] word_length_select,
  output logic timeout_enable,
  output logic [2:0] chan_convert_enable,
  // Ready pin.
  output logic sample_ready_pin_o,
  output logic sample_ready_pin_oe
);
  import asm_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  asm_word_t mode;
  logic [2:0] chen;
  logic resync_event_flag;
  logic map_flag;
  logic crc_err_flag;
  logic [2:0] new_sample;
  asm_word_t status_word;

  // Write channel holding state.
  logic aw_held;
  logic w_held;
  asm_addr_t aw_addr;
  asm_data_t w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic wr_mode;
  logic wr_chen;
  logic rd_take;
  logic rd_status;

  // Ready pin state.
  asm_pin_e pin_state;
  asm_pin_e next_pin_state;
  logic avail;
  logic avail_q;
  logic [1:0] pulse_cnt;

  // ****************************************
  // Write path
  // ****************************************

  // Write happens once both halves are held and no response waits.
  assign do_write = aw_held && w_held && !saxi_bvalid;
  assign wr_mode = do_write && (aw_addr == `ASM_ADDR(`ASM_MODE_IDX));
  assign wr_chen = do_write && (aw_addr == `ASM_ADDR(`ASM_CHEN_IDX));

  // Address channel capture, either order with data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 6'h00;
      saxi_awready <= 1'b1;
    end else if (ce) begin
      if (saxi_awvalid && saxi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= saxi_awaddr;
        saxi_awready <= 1'b0;
      end else if (saxi_bvalid && saxi_bready) begin
        aw_held <= 1'b0;
        saxi_awready <= 1'b1;
      end
    end
  end

  // Data channel capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      saxi_wready <= 1'b1;
    end else if (ce) begin
      if (saxi_wvalid && saxi_wready) begin
        w_held <= 1'b1;
        w_data <= saxi_wdata;
        w_strb <= saxi_wstrb;
        saxi_wready <= 1'b0;
      end else if (saxi_bvalid && saxi_bready) begin
        w_held <= 1'b0;
        saxi_wready <= 1'b1;
      end
    end
  end

  // Write response; read-only and unmapped words answer an error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      saxi_bvalid <= 1'b0;
      saxi_bresp <= `ASM_RESP_OK;
    end else if (ce) begin
      if (do_write) begin
        saxi_bvalid <= 1'b1;
        saxi_bresp <= (wr_mode || wr_chen) ? `ASM_RESP_OK : `ASM_RESP_ERR;
      end else if (saxi_bready) begin
        saxi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Mode and channel enable registers
  // ****************************************

  // mode reset value.
  // Mode register with byte lanes; reset flag bit clears only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= `ASM_MODE_RST;
    end else if (ce && wr_mode) begin
      if (w_strb[0]) begin
        mode[7:0] <= w_data[7:0];
      end
      if (w_strb[1]) begin
        mode[15:11] <= w_data[15:11];
        mode[9:8] <= w_data[9:8];
        if (!w_data[`ASM_MD_RST]) begin
          mode[`ASM_MD_RST] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chen <= `ASM_CHEN_RST;
    end else if (ce && wr_chen && w_strb[0]) begin
      chen <= w_data[2:0];
    end
  end

  // Configuration outputs straight from the mode and channel enable flops.
  // drive converter.
  assign map_crc_enable = mode[`ASM_MD_MAP_EN];
  assign rx_crc_enable = mode[`ASM_MD_RX_EN];
  assign crc_poly_select = mode[`ASM_MD_POLY];
  assign word_length_select = mode[`ASM_MD_WLEN];
  assign timeout_enable = mode[`ASM_MD_TMO];
  assign chan_convert_enable = chen;

  // ****************************************
  // Status flags
  // ****************************************

  assign rd_take = saxi_arvalid && saxi_arready;
  assign rd_status = rd_take && (saxi_araddr == `ASM_ADDR(`ASM_STATUS_IDX));

  // resync sticky flag.
  // A status read clears the flag; a new event in that cycle wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resync_event_flag <= 1'b0;
    end else if (ce) begin
      if (resync_pulse) begin
        resync_event_flag <= 1'b1;
      end else if (rd_status) begin
        resync_event_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      map_flag <= 1'b0;
    end else if (ce) begin
      if (map_crc_change_pulse && mode[`ASM_MD_MAP_EN]) begin
        map_flag <= 1'b1;
      end else if (rd_status) begin
        map_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crc_err_flag <= 1'b0;
    end else if (ce) begin
      if (rx_crc_error_pulse && mode[`ASM_MD_RX_EN]) begin
        crc_err_flag <= 1'b1;
      end else if (rd_status) begin
        crc_err_flag <= 1'b0;
      end
    end
  end

  // per-channel new data flags.
  // Each flag sets on its channel pulse while that channel is enabled and clears when data are read.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_new
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          new_sample[gi] <= 1'b0;
        end else if (ce) begin
          if (chan_sample_pulse[gi] && chen[gi]) begin
            new_sample[gi] <= 1'b1;
          end else if (sample_data_read_pulse) begin
            new_sample[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // status word.
  // Lock, sticky flags, mirrored mode fields, zero reserved bits.
  always_comb begin
    status_word = 16'h0000;
    status_word[`ASM_ST_LOCK] = lock_state;
    status_word[`ASM_ST_RESYNC] = resync_event_flag;
    status_word[`ASM_ST_MAP] = map_flag;
    status_word[`ASM_ST_CRCERR] = crc_err_flag;
    status_word[`ASM_MD_POLY] = mode[`ASM_MD_POLY];
    status_word[`ASM_MD_RST] = mode[`ASM_MD_RST];
    status_word[`ASM_MD_WLEN] = mode[`ASM_MD_WLEN];
    status_word[`ASM_ST_NEW] = new_sample;
  end

  // ****************************************
  // Read path
  // ****************************************

  // status decode.
  // One read at a time; data captured at the address handshake.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      saxi_arready <= 1'b1;
      saxi_rvalid <= 1'b0;
      saxi_rdata <= 32'h00000000;
      saxi_rresp <= `ASM_RESP_OK;
    end else if (ce) begin
      if (rd_take) begin
        saxi_arready <= 1'b0;
        saxi_rvalid <= 1'b1;
        saxi_rresp <= `ASM_RESP_OK;
        case (saxi_araddr)
          `ASM_ADDR(`ASM_STATUS_IDX): begin
            saxi_rdata <= {16'h0000, status_word};
          end
          `ASM_ADDR(`ASM_MODE_IDX): begin
            saxi_rdata <= {16'h0000, mode};
          end
          `ASM_ADDR(`ASM_CHEN_IDX): begin
            saxi_rdata <= {29'h00000000, chen};
          end
          default: begin
            saxi_rdata <= 32'h00000000;
            saxi_rresp <= `ASM_RESP_ERR;
          end
        endcase
      end else if (saxi_rvalid && saxi_rready) begin
        saxi_rvalid <= 1'b0;
        saxi_arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // Ready pin
  // ****************************************

  always_comb begin
    case (mode[`ASM_MD_SRC])
      `ASM_SRC_LAG: begin
        avail = (chen != 3'h0) && ((new_sample & chen) == chen);
      end
      `ASM_SRC_OR: begin
        avail = |(new_sample & chen);
      end
      default: begin
        avail = |(new_sample & chen);
      end
    endcase
  end

  // Pin state: level follows avail; pulse fires on each rise seen in idle, not on a rise during a pulse.
  always_comb begin
    next_pin_state = pin_state;
    case (pin_state)
      ASM_PIN_IDLE: begin
        if (avail && !avail_q) begin
          next_pin_state = mode[`ASM_MD_FMT] ? ASM_PIN_PULSE : ASM_PIN_LEVEL;
        end else if (avail && !mode[`ASM_MD_FMT]) begin
          next_pin_state = ASM_PIN_LEVEL;
        end
      end
      ASM_PIN_LEVEL: begin
        if (!avail || mode[`ASM_MD_FMT]) begin
          next_pin_state = ASM_PIN_IDLE;
        end
      end
      ASM_PIN_PULSE: begin
        if (pulse_cnt == 2'(`ASM_PULSE_CYC - 1)) begin
          next_pin_state = ASM_PIN_IDLE;
        end
      end
      default: begin
        next_pin_state = ASM_PIN_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_state <= ASM_PIN_IDLE;
      avail_q <= 1'b0;
      pulse_cnt <= 2'h0;
    end else if (ce) begin
      pin_state <= next_pin_state;
      avail_q <= avail;
      if (next_pin_state == ASM_PIN_PULSE && pin_state == ASM_PIN_PULSE) begin
        pulse_cnt <= pulse_cnt + 2'h1;
      end else begin
        pulse_cnt <= 2'h0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_ready_pin_o <= 1'b1;
      sample_ready_pin_oe <= 1'b1;
    end else if (ce) begin
      if (next_pin_state != ASM_PIN_IDLE) begin
        sample_ready_pin_o <= 1'b0;
        sample_ready_pin_oe <= 1'b1;
      end else begin
        sample_ready_pin_o <= 1'b1;
        sample_ready_pin_oe <= !mode[`ASM_MD_HIZ];
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_mode_wr_clear;
    ce && wr_mode && w_strb[1] && !w_data[`ASM_MD_RST];
  endsequence

  sequence s_status_rd;
    ce && rd_status;
  endsequence

  a_lock_readback: assert property (
    s_status_rd ##1 1'b1 |-> saxi_rvalid && saxi_rdata[`ASM_ST_LOCK] == $past(lock_state))
    else $error("lock bit wrong on status read");

  a_resync_sets: assert property (
    ce && resync_pulse |=> resync_event_flag)
    else $error("resync flag not set");

  a_map_sets: assert property (
    ce && map_crc_change_pulse && map_crc_enable |=> map_flag)
    else $error("map checksum flag not set");

  a_crc_err_sets: assert property (
    ce && rx_crc_error_pulse && rx_crc_enable |=> crc_err_flag)
    else $error("input checksum flag not set");

  a_mirror_fields: assert property (
    s_status_rd |=> saxi_rdata[11:8] == $past(mode[11:8]))
    else $error("status mirror fields differ from mode");

  a_reserved_zero: assert property (
    s_status_rd |=> saxi_rdata[`ASM_ST_RSVD] == 5'h00 && saxi_rdata[31:16] == 16'h0000)
    else $error("reserved status bits not zero");

  a_reset_clears: assert property (
    s_mode_wr_clear |=> !mode[`ASM_MD_RST] && saxi_bvalid)
    else $error("reset flag not cleared by write");

  a_new_sample: assert property (
    ce && chan_sample_pulse[0] && chen[0] |=> new_sample[0])
    else $error("new data flag not set");

  a_mode_reset: assert property (
    $rose(aresetn) |-> mode == `ASM_MODE_RST && status_word[11:0] == 12'h500)
    else $error("reset values wrong");

  a_float_idle: assert property (
    ce && next_pin_state == ASM_PIN_IDLE && mode[`ASM_MD_HIZ] |=> !sample_ready_pin_oe)
    else $error("idle pin not floating");

  a_pulse_width: assert property (
    ce && $rose(sample_ready_pin_oe && !sample_ready_pin_o) && mode[`ASM_MD_FMT]
    |-> (!sample_ready_pin_o && ce) [*2] ##1 sample_ready_pin_o)
    else $error("pulse width wrong");
endmodule

// *** design/asm_regs.svh ***
`ifndef ASM_REGS_SVH
`define ASM_REGS_SVH
// Register indices; byte address is four times the index.
`define ASM_STATUS_IDX 4'h1
`define ASM_MODE_IDX 4'h2
`define ASM_CHEN_IDX 4'h3
`define ASM_ADDR(i) ({(i), 2'h0})
// Reset values.
`define ASM_STATUS_RST 16'h0500
`define ASM_MODE_RST 16'h0510
`define ASM_CHEN_RST 3'h7
// Status fields.
`define ASM_ST_LOCK 15
`define ASM_ST_RESYNC 14
`define ASM_ST_MAP 13
`define ASM_ST_CRCERR 12
`define ASM_ST_RSVD 7:3
`define ASM_ST_NEW 2:0
// Mode fields; bits 11:8 are mirrored into status at the same positions.
`define ASM_MD_RSVD_HI 15:14
`define ASM_MD_MAP_EN 13
`define ASM_MD_RX_EN 12
`define ASM_MD_POLY 11
`define ASM_MD_RST 10
`define ASM_MD_WLEN 9:8
`define ASM_MD_RSVD_LO 7:5
`define ASM_MD_TMO 4
`define ASM_MD_SRC 3:2
`define ASM_MD_HIZ 1
`define ASM_MD_FMT 0
// Source select codes.
`define ASM_SRC_LAG 2'h0
`define ASM_SRC_OR 2'h1
// AXI responses.
`define ASM_RESP_OK 2'h0
`define ASM_RESP_ERR 2'h2
// Pulse timing.
`define ASM_CLK_NS 20
`define ASM_PULSE_NS 40
`define ASM_PULSE_CYC (((`ASM_PULSE_NS) + (`ASM_CLK_NS) - 1) / (`ASM_CLK_NS))
`endif

// *** design/asm_pkg.sv ***
package asm_pkg;
  typedef logic [31:0] asm_data_t;
  typedef logic [5:0] asm_addr_t;
  typedef logic [15:0] asm_word_t;
  // Ready pin states.
  typedef enum logic [1:0] {
    ASM_PIN_IDLE = 2'b00,
    ASM_PIN_LEVEL = 2'b01,
    ASM_PIN_PULSE = 2'b10
  } asm_pin_e;
endpackage

// *** tb/asm_host_model.sv ***
`timescale 1ns/100ps
`include "asm_regs.svh"
// ********************
// Host bus master.
// ********************
module asm_host_model (
  // Clock.
  input wire logic aclk,
  // Write channels.
  output logic saxi_awvalid,
  input wire logic saxi_awready,
  output asm_pkg::asm_addr_t saxi_awaddr,
  output logic saxi_wvalid,
  input wire logic saxi_wready,
  output asm_pkg::asm_data_t saxi_wdata,
  output logic [3:0] saxi_wstrb,
  input wire logic saxi_bvalid,
  output logic saxi_bready,
  input wire logic [1:0] saxi_bresp,
  // Read channels.
  output logic saxi_arvalid,
  input wire logic saxi_arready,
  output asm_pkg::asm_addr_t saxi_araddr,
  input wire logic saxi_rvalid,
  output logic saxi_rready,
  input wire asm_pkg::asm_data_t saxi_rdata,
  input wire logic [1:0] saxi_rresp
);
  import asm_pkg::*;
  // Cycles the host stalls before it takes an answer.
  int lag = 0;
  // The bus starts idle.
  initial begin
    {saxi_awvalid, saxi_wvalid, saxi_bready, saxi_arvalid, saxi_rready} = '0;
    {saxi_awaddr, saxi_araddr, saxi_wdata, saxi_wstrb} = '0;
  end
  // One write; released payload is inverted so stale values never match.
  task automatic wr(input asm_addr_t a, input asm_data_t d, output logic [1:0] r);
    int n;
    n = 0;
    if (a == `ASM_ADDR(`ASM_MODE_IDX)) d = d & 32'hFFFF3F1F;
    @(posedge aclk);
    saxi_awvalid <= 1'b1;
    saxi_awaddr <= a;
    saxi_wvalid <= 1'b1;
    saxi_wdata <= d;
    saxi_wstrb <= 4'hF;
    saxi_bready <= (lag == 0);
    while (n < 200) begin
      @(posedge aclk);
      n++;
      if (saxi_awvalid && saxi_awready) begin
        saxi_awvalid <= 1'b0;
        saxi_awaddr <= ~a;
      end
      if (saxi_wvalid && saxi_wready) begin
        saxi_wvalid <= 1'b0;
        saxi_wdata <= ~d;
      end
      if (saxi_bready && saxi_bvalid) begin
        r = saxi_bresp;
        saxi_bready <= 1'b0;
        n = 999;
      end else if (n >= lag) begin
        saxi_bready <= 1'b1;
      end
    end
  endtask
  // One read.
  task automatic rd(input asm_addr_t a, output asm_data_t d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    saxi_arvalid <= 1'b1;
    saxi_araddr <= a;
    saxi_rready <= (lag == 0);
    while (n < 200) begin
      @(posedge aclk);
      n++;
      if (saxi_arvalid && saxi_arready) begin
        saxi_arvalid <= 1'b0;
        saxi_araddr <= ~a;
      end
      if (saxi_rready && saxi_rvalid) begin
        d = saxi_rdata;
        r = saxi_rresp;
        saxi_rready <= 1'b0;
        n = 999;
      end else if (n >= lag) begin
        saxi_rready <= 1'b1;
      end
    end
  endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/100ps
`include "asm_regs.svh"
module tb;
  import asm_pkg::*;
  // ********************
  // Signals and instances.
  // ********************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic lock_state = 1'b0;
  logic [6:0] ev = '0;
  int fails = 0;
  int checks_done = 0;
  logic saxi_awvalid, saxi_awready, saxi_wvalid, saxi_wready, saxi_bvalid, saxi_bready;
  logic saxi_arvalid, saxi_arready, saxi_rvalid, saxi_rready;
  asm_addr_t saxi_awaddr, saxi_araddr;
  asm_data_t saxi_wdata, saxi_rdata, got;
  logic [3:0] saxi_wstrb;
  logic [1:0] saxi_bresp, saxi_rresp, word_length_select, resp;
  logic map_crc_enable, rx_crc_enable, crc_poly_select, timeout_enable;
  logic sample_ready_pin_o, sample_ready_pin_oe;
  logic [2:0] chan_convert_enable;
  localparam asm_addr_t A_ST = `ASM_ADDR(`ASM_STATUS_IDX);
  localparam asm_addr_t A_MD = `ASM_ADDR(`ASM_MODE_IDX);
  localparam asm_addr_t A_CH = `ASM_ADDR(`ASM_CHEN_IDX);
  // Converter events come from one vector.
  wire resync_pulse = ev[0];
  wire map_crc_change_pulse = ev[1];
  wire rx_crc_error_pulse = ev[2];
  wire [2:0] chan_sample_pulse = ev[5:3];
  wire sample_data_read_pulse = ev[6];
  wire [5:0] cfg = {map_crc_enable, rx_crc_enable, crc_poly_select, word_length_select,
    timeout_enable};
  // Clock at 50 MHz.
  always #10 aclk = ~aclk;
  asm_status_mode i_asm_status_mode (.ce(1'b1), .*);
  asm_host_model i_asm_host_model (.*);
  // ********************
  // Helpers.
  // ********************
  task automatic chk_val(input asm_data_t g, input asm_data_t e, input string what);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e, input string what);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: %s response %h expected %h", $time, what, g, e);
    end
  endtask
  task automatic rd_chk(input asm_addr_t a, input asm_data_t e, input string what);
    i_asm_host_model.rd(a, got, resp);
    chk_resp(resp, `ASM_RESP_OK, what);
    chk_val(got, e, what);
  endtask
  task automatic wr_ok(input asm_addr_t a, input asm_data_t d);
    i_asm_host_model.wr(a, d, resp);
    chk_resp(resp, `ASM_RESP_OK, "write");
  endtask
  task automatic pulse(input logic [6:0] m);
    @(posedge aclk);
    ev <= m;
    @(posedge aclk);
    ev <= '0;
  endtask
  // Pin level is only judged while the pin is driven.
  task automatic pin(input logic o, input logic oe, input string what);
    @(posedge aclk);
    #1;
    chk_val({30'h0, sample_ready_pin_oe, sample_ready_pin_oe & sample_ready_pin_o},
      {30'h0, oe, o & oe}, what);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ********************
  // Scenarios.
  // ********************
  task automatic t_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk_val({26'h0, cfg}, 32'h3, "config after reset");
    rd_chk(A_ST, {16'h0, `ASM_STATUS_RST}, "status reset");
    rd_chk(A_MD, {16'h0, `ASM_MODE_RST}, "mode reset");
    rd_chk(A_CH, 32'h7, "enables reset");
    $display("test reset done");
  endtask
  task automatic t_mode;
    wr_ok(A_MD, 32'h3B1C);
    rd_chk(A_MD, 32'h3B1C, "mode readback");
    rd_chk(A_ST, 32'h0B00, "status mirror");
    chk_val({26'h0, cfg}, 32'h3F, "config out");
    for (int k = 0; k < 4; k++) begin
      wr_ok(A_MD, {20'h0, k[0], 1'b0, k[1:0], 8'h10});
      rd_chk(A_ST, {20'h0, k[0], 1'b0, k[1:0], 8'h00}, "word length");
      chk_val({26'h0, cfg}, {26'h0, 2'b00, k[0], k[1:0], 1'b1}, "fields");
    end
    wr_ok(A_MD, 32'h0);
    chk_val({26'h0, cfg}, 32'h0, "timeout off");
    $display("test mode done");
  endtask
  task automatic t_flags;
    pulse(7'h07);
    rd_chk(A_ST, 32'h4000, "resync only");
    rd_chk(A_ST, 32'h0000, "cleared by read");
    wr_ok(A_MD, 32'h3000);
    lock_state <= 1'b1;
    pulse(7'h06);
    rd_chk(A_ST, 32'hB000, "lock and errors");
    lock_state <= 1'b0;
    rd_chk(A_ST, 32'h0000, "unlocked");
    wr_ok(A_MD, 32'h0);
    $display("test flags done");
  endtask
  task automatic t_bus;
    i_asm_host_model.lag = 3;
    i_asm_host_model.wr(A_ST, 32'hFFFF, resp);
    chk_resp(resp, `ASM_RESP_ERR, "status write");
    rd_chk(A_ST, 32'h0, "status unchanged");
    i_asm_host_model.rd(6'h10, got, resp);
    chk_resp(resp, `ASM_RESP_ERR, "unmapped read");
    chk_val(got, 32'h0, "unmapped data");
    i_asm_host_model.wr(6'h3C, 32'h1, resp);
    chk_resp(resp, `ASM_RESP_ERR, "unmapped write");
    rd_chk(A_MD, 32'h0, "mode unchanged");
    i_asm_host_model.lag = 0;
    $display("test bus done");
  endtask
  task automatic t_pin;
    pulse(7'h18);
    pin(1'b1, 1'b1, "two of three");
    rd_chk(A_ST, 32'h3, "new data");
    pulse(7'h20);
    pin(1'b0, 1'b1, "all three");
    pulse(7'h40);
    pin(1'b1, 1'b1, "driven idle");
    wr_ok(A_CH, 32'h1);
    pulse(7'h20);
    rd_chk(A_ST, 32'h0, "disabled channel");
    pulse(7'h08);
    pin(1'b0, 1'b1, "only enabled");
    pulse(7'h40);
    wr_ok(A_CH, 32'h7);
    for (int c = 1; c < 4; c++) begin
      wr_ok(A_MD, {28'h0, c[1:0], 2'b00});
      pulse(7'h20);
      pin(1'b0, 1'b1, "source code");
      pulse(7'h40);
      pin(1'b1, 1'b1, "source idle");
    end
    wr_ok(A_MD, 32'h7);
    pin(1'b1, 1'b0, "float idle");
    pulse(7'h10);
    pin(1'b0, 1'b1, "pulse first");
    pin(1'b0, 1'b1, "pulse second");
    pin(1'b1, 1'b0, "pulse end");
    pulse(7'h40);
    $display("test pin done");
  endtask
  // Main sequence, with a second reset at the end.
  initial begin
    t_reset;
    t_mode;
    t_flags;
    t_bus;
    t_pin;
    t_reset;
    stop_test;
  end
  // Watchdog, far beyond the few hundred cycles the run needs.
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    stop_test;
  end
endmodule
